// ===== core/prbs_pkg.sv
// Shared constants for the pseudorandom status and tap/seed block.
// Assumes one 50 MHz clock and an 8-bit parallel control port.
package prbs_pkg;
    localparam logic [3:0] ctrl1_addr = 4'h0;
    localparam logic [3:0] ctrl2_addr = 4'h1;
    localparam logic [3:0] ctrl4_addr = 4'h3;
    localparam logic [3:0] status_addr = 4'h4;
    localparam logic [3:0] tap_seed_byte0_addr = 4'h5;
    localparam logic [3:0] tap_seed_byte3_addr = 4'h8;
    localparam int seed_load_pos = 0;
    localparam int quasi_random_pos = 3;
    localparam int rx_invert_pos = 4;
    localparam int tx_invert_pos = 5;
    localparam int mode_lo_pos = 6;
    localparam int seed_sel_pos = 1;
    localparam int sync_pos = 0;
    localparam int lock_lost_pos = 1;
    localparam int bit_wrap_pos = 2;
    localparam int err_wrap_pos = 3;
    localparam int err_seen_pos = 4;
    localparam int all_zeros_pos = 5;
    localparam int all_ones_pos = 6;
    localparam logic [5:0] run_limit = 6'd40;
    localparam logic [5:0] min_order_nibble = 6'd4;
    localparam logic [5:0] min_order_byte = 6'd8;
    localparam logic [7:0] reg_reset = 8'h00;
    localparam logic [31:0] word_reset = 32'h0000_0000;
    localparam int fifo_width = 8;
    localparam int fifo_depth = 8;
    typedef enum logic [1:0] {mode_bit, mode_nibble, mode_byte, mode_bad} lane_mode_t;
endpackage

// ===== core/prbs_fifo.sv
// Small synchronous FIFO with valid/ready on both sides.
// Assumes both sides share clk.
`timescale 1ns/1ps
module prbs_fifo #(
    parameter int width = 8,
    parameter int depth = 8
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [width-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [width-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int aw = $clog2(depth);
    logic [width-1:0] mem [depth];
    logic [aw-1:0] wr_r;
    logic [aw-1:0] rd_r;
    logic [aw:0] cnt_r;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;
    assign in_ready = (cnt_r != (aw+1)'(depth));
    assign out_valid = (cnt_r != '0);
    assign out_data = mem[rd_r];
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_r] <= in_data;
        end
    end
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_r <= '0;
            rd_r <= '0;
            cnt_r <= '0;
        end else begin
            if (push) begin
                wr_r <= (wr_r == aw'(depth - 1)) ? '0 : aw'(wr_r + 1'b1);
            end
            if (pop) begin
                rd_r <= (rd_r == aw'(depth - 1)) ? '0 : aw'(rd_r + 1'b1);
            end
            cnt_r <= (aw+1)'(cnt_r + {{aw{1'b0}}, push} - {{aw{1'b0}}, pop});
        end
    end
endmodule

// ===== core/prbs_lfsr.sv
// Programmable Fibonacci shift register producing one bit a step.
// Assumes taps with bit n-1 set give a register of length n.
`timescale 1ns/1ps
module prbs_lfsr (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [31:0] taps,
    input wire logic [31:0] seed,
    input wire logic load,
    input wire logic step,
    output logic bit_out
);
    logic [31:0] sr_r;
    // Feedback is the parity of the tapped stages.
    wire fb = ^(sr_r & taps);
    assign bit_out = fb;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sr_r <= 32'hffff_ffff;
        end else if (load) begin
            sr_r <= seed;
        end else if (step) begin
            sr_r <= {sr_r[30:0], fb};
        end
    end
endmodule

// ===== core/prbs_status_and_taps.sv
// Status flags and tap/seed registers of a pattern tester, with generator and checker.
// Assumes rx inputs arrive from pins asynchronous to clk; control port is synchronous.
`timescale 1ns/1ps
module prbs_status_and_taps
    import prbs_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [3:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [7:0] rd_data,
    input wire logic rx_bit,
    input wire logic rx_bit_en,
    output logic [7:0] tx_data,
    output logic tx_valid,
    input wire logic tx_ready
);
    ////////////////////////////////////////////////////////////////////////////
    logic [7:0] ctrl1_r;
    logic [7:0] ctrl2_r;
    logic [7:0] ctrl4_r;
    logic [31:0] taps_r;
    logic [31:0] seed_r;
    logic seed_load_d_r;
    logic [6:0] flags_r;
    logic [7:0] rd_data_r;
    logic rx_s1_r, rx_s2_r, en_s1_r, en_s2_r;

    function automatic logic [5:0] poly_order(input logic [31:0] t);
        logic [5:0] o;
        o = 6'd0;
        for (int i = 0; i < 32; i++) begin
            if (t[i]) begin
                o = 6'(i + 1);
            end
        end
        return o;
    endfunction

    wire seed_sel = ctrl4_r[seed_sel_pos];
    wire tx_invert_sel = ctrl2_r[tx_invert_pos];
    wire rx_invert_sel = ctrl2_r[rx_invert_pos];
    wire quasi_random_select = ctrl1_r[quasi_random_pos];
    wire seed_load_bit = ctrl1_r[seed_load_pos];
    wire lane_mode_t lane_mode = lane_mode_t'(ctrl2_r[mode_lo_pos +: 2]);
    wire in_window = (addr >= tap_seed_byte0_addr) && (addr <= tap_seed_byte3_addr);
    wire [1:0] byte_idx = 2'(addr - tap_seed_byte0_addr);
    wire status_read = rd_en && (addr == status_addr);
    wire seed_load_rise = seed_load_bit && !seed_load_d_r;
    wire [5:0] order = poly_order(taps_r);

    ////////////////////////////////////////////////////////////////////////////
    // Control and tap/seed registers.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl1_r <= reg_reset;
            ctrl2_r <= reg_reset;
            ctrl4_r <= reg_reset;
            taps_r <= word_reset;
            seed_r <= word_reset;
            seed_load_d_r <= 1'b0;
        end else begin
            seed_load_d_r <= seed_load_bit;
            if (wr_en && addr == ctrl1_addr) begin
                ctrl1_r <= wr_data;
            end
            if (wr_en && addr == ctrl2_addr) begin
                ctrl2_r <= wr_data;
            end
            if (wr_en && addr == ctrl4_addr) begin
                ctrl4_r <= wr_data;
            end
            if (wr_en && in_window && !seed_sel) begin
                taps_r[byte_idx*8 +: 8] <= wr_data;
            end
            if (wr_en && in_window && seed_sel) begin
                seed_r[byte_idx*8 +: 8] <= wr_data;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Transmit generator feeding the FIFO one word per beat.
    logic [7:0] gen_word_r;
    logic [3:0] gen_cnt_r;
    logic gen_valid_r;
    wire gen_ready;
    wire gen_bit;
    wire gen_step = !gen_valid_r || gen_ready;
    wire [3:0] gen_need = (lane_mode == mode_byte) ? 4'd8 :
                          (lane_mode == mode_nibble) ? 4'd4 : 4'd1;
    wire too_short = (lane_mode == mode_nibble && order < min_order_nibble) ||
                     (lane_mode == mode_byte && order < min_order_byte);
    wire gen_out = (too_short ? 1'b1 : gen_bit) ^ tx_invert_sel;

    prbs_lfsr u_tx_lfsr (
        .clk(clk),
        .rst_b(rst_b),
        .taps(taps_r),
        .seed(seed_r),
        .load(seed_load_rise),
        .step(gen_step && !seed_load_rise),
        .bit_out(gen_bit)
    );

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            gen_word_r <= reg_reset;
            gen_cnt_r <= 4'd0;
            gen_valid_r <= 1'b0;
        end else if (gen_step) begin
            gen_word_r <= {gen_word_r[6:0], gen_out};
            gen_cnt_r <= (gen_cnt_r + 4'd1 >= gen_need) ? 4'd0 : 4'(gen_cnt_r + 4'd1);
            gen_valid_r <= (gen_cnt_r + 4'd1 >= gen_need);
        end
    end

    prbs_fifo #(.width(fifo_width), .depth(fifo_depth)) u_tx_fifo (
        .clk(clk),
        .rst_b(rst_b),
        .in_data(gen_word_r),
        .in_valid(gen_valid_r),
        .in_ready(gen_ready),
        .out_data(tx_data),
        .out_valid(tx_valid),
        .out_ready(tx_ready)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Receive checker: self-synchronising compare against a local register.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rx_s1_r <= 1'b0;
            rx_s2_r <= 1'b0;
            en_s1_r <= 1'b0;
            en_s2_r <= 1'b0;
        end else begin
            rx_s1_r <= rx_bit;
            rx_s2_r <= rx_s1_r;
            en_s1_r <= rx_bit_en;
            en_s2_r <= en_s1_r;
        end
    end

    logic [31:0] rx_sr_r;
    logic [5:0] good_cnt_r, bad_cnt_r, ones_r, zeros_r;
    logic in_sync_r;
    logic [47:0] bit_cnt_r, err_cnt_r;
    wire rx_in = rx_s2_r ^ rx_invert_sel;
    wire rx_pred = ^(rx_sr_r & taps_r);
    wire rx_err = en_s2_r && (rx_pred != rx_in);
    wire count_err = rx_err && in_sync_r;
    wire bit_wrap = en_s2_r && (&bit_cnt_r);
    wire err_wrap = count_err && (&err_cnt_r);
    wire ones_cond = (ones_r == run_limit);
    wire zeros_cond = (zeros_r == run_limit);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rx_sr_r <= word_reset;
            good_cnt_r <= 6'd0;
            bad_cnt_r <= 6'd0;
            ones_r <= 6'd0;
            zeros_r <= 6'd0;
            in_sync_r <= 1'b0;
            bit_cnt_r <= '0;
            err_cnt_r <= '0;
        end else if (en_s2_r) begin
            rx_sr_r <= {rx_sr_r[30:0], rx_in};
            ones_r <= !rx_in ? 6'd0 : (ones_cond ? ones_r : 6'(ones_r + 6'd1));
            zeros_r <= rx_in ? 6'd0 : (zeros_cond ? zeros_r : 6'(zeros_r + 6'd1));
            bit_cnt_r <= 48'(bit_cnt_r + 48'd1);
            if (count_err) begin
                err_cnt_r <= 48'(err_cnt_r + 48'd1);
            end
            if (!in_sync_r) begin
                good_cnt_r <= rx_err ? 6'd0 : 6'(good_cnt_r + 6'd1);
                in_sync_r <= !rx_err && (good_cnt_r + 6'd1 >= 6'(order) + 6'd1);
                bad_cnt_r <= 6'd0;
            end else begin
                bad_cnt_r <= rx_err ? 6'(bad_cnt_r + 6'd1) : 6'd0;
                in_sync_r <= !(rx_err && bad_cnt_r + 6'd1 >= 6'(order));
                good_cnt_r <= 6'd0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Latched event flags; a new event in the read cycle wins over the clear.
    wire pr_mode = !quasi_random_select;
    wire [6:0] set_vec;
    wire [6:0] hold_vec;
    assign set_vec[sync_pos] = 1'b0;
    assign set_vec[lock_lost_pos] = !in_sync_r;
    assign set_vec[bit_wrap_pos] = bit_wrap;
    assign set_vec[err_wrap_pos] = err_wrap;
    assign set_vec[err_seen_pos] = count_err || (err_cnt_r != '0);
    assign set_vec[all_zeros_pos] = pr_mode && zeros_cond;
    assign set_vec[all_ones_pos] = pr_mode && ones_cond;
    assign hold_vec = status_read ? 7'h00 : flags_r;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            flags_r <= 7'h00;
        end else begin
            flags_r <= (set_vec | hold_vec) & 7'h7e;
        end
    end

    // Lock-lost also reads high while hunting, so a read in the cycle sync drops is not missed.
    wire [7:0] status_view = {1'b0, flags_r[6:2], flags_r[1] | !in_sync_r, in_sync_r};
    wire [31:0] win_word = seed_sel ? seed_r : taps_r;
    wire [7:0] rd_mux = (addr == status_addr) ? status_view :
                        in_window ? win_word[byte_idx*8 +: 8] :
                        (addr == ctrl1_addr) ? ctrl1_r :
                        (addr == ctrl2_addr) ? ctrl2_r :
                        (addr == ctrl4_addr) ? ctrl4_r : 8'h00;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rd_data_r <= 8'h00;
        end else if (rd_en) begin
            rd_data_r <= rd_mux;
        end
    end
    assign rd_data = rd_data_r;
endmodule

// ===== testbench/prbs_status_and_taps_props.sv
// Port-level checker for the status and tap/seed block.
// Assumes reads are spaced so that each result is held for two cycles.
`timescale 1ns/1ps
module prbs_status_and_taps_props
    import prbs_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [3:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [7:0] rd_data,
    input wire logic rx_bit,
    input wire logic rx_bit_en,
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    input wire logic tx_ready
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    ////////////////////////////////////////////////////////////////////////
    sequence st_rd;
        rd_en && addr == status_addr ##1 !rd_en;
    endsequence
    sequence tap_wr_rd;
        wr_en && !rd_en && addr >= tap_seed_byte0_addr && addr <= tap_seed_byte3_addr
        ##1 !wr_en ##1 rd_en && !wr_en && addr == $past(addr, 2) ##1 !rd_en && !wr_en;
    endsequence
    ////////////////////////////////////////////////////////////////////////
    AST_TAP_READBACK: assert property (tap_wr_rd |=> rd_data == $past(wr_data, 4))
        else $error("tap or seed byte read back wrong");
    AST_RD_MSB: assert property (st_rd |=> !rd_data[7])
        else $error("status bit 7 not zero");
    AST_RD_HOLD: assert property (!$past(rd_en) && !$past(rd_en, 2) |-> $stable(rd_data))
        else $error("read data moved without a read");
    AST_UNMAPPED: assert property (
        rd_en && addr > tap_seed_byte3_addr ##1 !rd_en |=> rd_data == 8'h00)
        else $error("unmapped address read nonzero");
    AST_LOCK_LOST: assert property (st_rd |=> rd_data[sync_pos] || rd_data[lock_lost_pos])
        else $error("out of lock without lock lost flag");
    AST_WRAP_CLEAR: assert property (st_rd
        |=> !rd_data[bit_wrap_pos] && !rd_data[err_wrap_pos])
        else $error("wrap flag set without counter wrap");
    AST_TX_HOLD: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
        else $error("transmit word dropped while stalled");
    AST_TX_AFTER_RESET: assert property ($rose(rst_b) |-> !tx_valid && rd_data == reg_reset)
        else $error("outputs not cleared by reset");
endmodule
bind prbs_status_and_taps prbs_status_and_taps_props u_props (.clk(clk), .rst_b(rst_b),
    .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .rx_bit(rx_bit), .rx_bit_en(rx_bit_en), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready));

// ===== testbench/prbs_line_model.sv
// Line-side stand-in: sends received bits in bursts and takes transmit words.
// Assumes the bench steers it through pat, on and stall.
`timescale 1ns/1ps
module prbs_line_model (
    input wire logic clk,
    input wire logic pat,
    input wire logic on,
    input wire logic stall,
    output logic rx_bit,
    output logic rx_bit_en,
    output logic tx_ready
);
    initial begin
        rx_bit = 1'b0;
        rx_bit_en = 1'b0;
        tx_ready = 1'b0;
    end
    // Outside a burst the data line toggles so a stale level never passes for data.
    always @(negedge clk) begin
        rx_bit_en <= on;
        rx_bit <= on ? pat : ~rx_bit;
        tx_ready <= !stall;
    end
endmodule

// ===== testbench/tb_top.sv
// Self-checking bench for the status and tap/seed block.
// Assumes the line model on the far side and the bound port checker.
`timescale 1ns/1ps
module tb_top
    import prbs_pkg::*;
;
    logic clk = 1'b0, rst_b = 1'b0, wr_en = 1'b0, rd_en = 1'b0;
    logic pat = 1'b0, on = 1'b0, stall = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wr_data = 8'h00, got;
    wire logic [7:0] rd_data, tx_data;
    wire logic rx_bit, rx_bit_en, tx_valid, tx_ready;
    int num_errors = 0, n_compared = 0, i, k;
    typedef struct {logic [7:0] ctrl2, tap0, mask, exp;} tx_row_t;
    tx_row_t rows [4] = '{'{8'h80, 8'h48, 8'hff, 8'hff},
        '{8'ha0, 8'h48, 8'hff, 8'h00}, '{8'h40, 8'h05, 8'h0f, 8'h0f},
        '{8'h60, 8'h05, 8'h0f, 8'h00}};
    always #10 clk = ~clk;
    prbs_status_and_taps dut (.clk(clk), .rst_b(rst_b), .addr(addr), .wr_data(wr_data),
        .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .rx_bit(rx_bit),
        .rx_bit_en(rx_bit_en), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready));
    prbs_line_model far (.clk(clk), .pat(pat), .on(on), .stall(stall), .rx_bit(rx_bit),
        .rx_bit_en(rx_bit_en), .tx_ready(tx_ready));
    ////////////////////////////////////////////////////////////////////////
    task chk(input logic [7:0] seen, input logic [7:0] expv);
        n_compared++;
        if (seen !== expv) begin
            num_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, expv);
        end
    endtask
    task wr(input logic [3:0] a, input logic [7:0] d);
        @(negedge clk);
        addr = a;
        wr_data = d;
        wr_en = 1'b1;
        @(negedge clk);
        wr_en = 1'b0;
    endtask
    task rd(input logic [3:0] a, output logic [7:0] d);
        @(negedge clk);
        addr = a;
        rd_en = 1'b1;
        @(negedge clk);
        rd_en = 1'b0;
        @(negedge clk);
        d = rd_data;
    endtask
    // Old words are flushed first so the sample belongs to the new setting.
    task tx_word(output logic [7:0] w);
        repeat (60) @(negedge clk);
        for (k = 0; k < 100 && tx_valid !== 1'b1; k++) @(negedge clk);
        if (tx_valid !== 1'b1) num_errors++;
        w = tx_data;
    endtask
    task tally_and_finish;
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        #400000;
        num_errors++;
        tally_and_finish;
    end
    initial begin
        repeat (3) @(posedge clk);
        @(negedge clk) rst_b = 1'b1;
        for (i = 0; i < 4; i++) begin
            wr(tap_seed_byte0_addr, rows[i].tap0);
            wr(ctrl2_addr, rows[i].ctrl2);
            tx_word(got);
            chk(got & rows[i].mask, rows[i].exp);
            $display("pattern row %0d done", i);
        end
        for (i = 0; i < 4; i++) wr(tap_seed_byte0_addr + 4'(i), 8'(8'h11 * (i + 1)));
        wr(ctrl4_addr, 8'h02);
        for (i = 0; i < 4; i++) wr(tap_seed_byte0_addr + 4'(i), 8'(8'ha1 + i));
        for (i = 0; i < 4; i++) begin
            rd(tap_seed_byte0_addr + 4'(i), got);
            chk(got, 8'(8'ha1 + i));
        end
        wr(ctrl4_addr, 8'h00);
        for (i = 0; i < 4; i++) begin
            rd(tap_seed_byte0_addr + 4'(i), got);
            chk(got, 8'(8'h11 * (i + 1)));
        end
        wr(4'hf, 8'h5a);
        rd(4'hf, got);
        chk(got, 8'h00);
        $display("register banks done");
        wr(ctrl2_addr, 8'h80);
        wr(ctrl4_addr, 8'h02);
        for (i = 0; i < 4; i++) wr(tap_seed_byte0_addr + 4'(i), 8'h00);
        wr(ctrl1_addr, 8'h01);
        tx_word(got);
        chk(got, 8'h00);
        wr(ctrl1_addr, 8'h00);
        wr(tap_seed_byte0_addr, 8'ha1);
        rd(tap_seed_byte0_addr, got);
        chk(got, 8'ha1);
        wr(ctrl1_addr, 8'h01);
        tx_word(got);
        chk({7'h0, got != 8'h00}, 8'h01);
        wr(ctrl4_addr, 8'h00);
        $display("seed load done");
        wr(ctrl2_addr, 8'h00);
        pat = 1'b1;
        on = 1'b1;
        repeat (50) @(negedge clk);
        rd(status_addr, got);
        chk(got & 8'h5f, 8'h42);
        rd(status_addr, got);
        chk(got & 8'h40, 8'h40);
        pat = 1'b0;
        repeat (50) @(negedge clk);
        rd(status_addr, got);
        chk(got & 8'h60, 8'h60);
        rd(status_addr, got);
        chk(got & 8'h60, 8'h20);
        $display("receive flags done");
        wr(ctrl1_addr, 8'h08);
        for (i = 0; i < 4; i++) wr(tap_seed_byte0_addr + 4'(i), (i == 2) ? 8'h09 : 8'h00);
        repeat (50) @(negedge clk);
        rd(status_addr, got);
        chk(got & 8'h01, 8'h01);
        rd(status_addr, got);
        chk(got & 8'h73, 8'h01);
        pat = 1'b1;
        repeat (60) @(negedge clk);
        rd(status_addr, got);
        chk(got & 8'h73, 8'h12);
        on = 1'b0;
        $display("quasi-random and sync done");
        stall = 1'b1;
        repeat (40) @(negedge clk);
        chk({7'h0, tx_valid}, 8'h01);
        stall = 1'b0;
        $display("stall done");
        tally_and_finish;
    end
endmodule
